// ===== beep_pkg.sv
/*
 * Shared constants, types and state records for the start-up beep and
 * blink sequencer.
 * Assumes a single 100 MHz core clock; all second-scale timing is
 * counted in quarter-second ticks.
 */
package beep_pkg;

    // ----------------------------------------------------------------
    // Clock and tick
    // ----------------------------------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int TICK_MS      = 250;
    localparam int TICK_CYC_DEF = TICK_MS * (CLK_HZ / 1000);
    localparam int PRE_W        = 25;

    // ----------------------------------------------------------------
    // Tone frequencies, as half periods in clock cycles
    // ----------------------------------------------------------------
    localparam int SETUP_HZ      = 932;
    localparam int HIGH_HZ       = 2000;
    localparam int LOW_HZ        = 1500;
    localparam int HALF_W        = 16;
    localparam int HALF_STD_DEF  = CLK_HZ / (2 * SETUP_HZ);
    localparam int HALF_HIGH_DEF = CLK_HZ / (2 * HIGH_HZ);
    localparam int HALF_LOW_DEF  = CLK_HZ / (2 * LOW_HZ);

    // ----------------------------------------------------------------
    // Pattern times, in ms and in ticks
    // ----------------------------------------------------------------
    typedef logic [5:0] pos_t;
    localparam int SETUP_BEEP_MS  = 500;
    localparam int UPD_PHASE_MS   = 500;
    localparam int ON_MS          = 1000;
    localparam int PAUSE_MS       = 2500;
    localparam int THERM_BEEP_MS  = 1000;
    localparam int THERM_BLINK_MS = 250;

    localparam pos_t SETUP_TK   = pos_t'(SETUP_BEEP_MS / TICK_MS);
    localparam pos_t UPD_TK     = pos_t'(UPD_PHASE_MS / TICK_MS);
    localparam pos_t ON_TK      = pos_t'(ON_MS / TICK_MS);
    localparam pos_t PAUSE_TK   = pos_t'(PAUSE_MS / TICK_MS);
    localparam pos_t TBEEP_TK   = pos_t'(THERM_BEEP_MS / TICK_MS);
    localparam pos_t TBLINK_TK  = pos_t'(THERM_BLINK_MS / TICK_MS);

    localparam pos_t VIDEO_CYCLES  = 6'h02;
    localparam pos_t MEMORY_CYCLES = 6'h03;
    localparam pos_t THERM_BEEPS   = 6'h08;
    localparam logic [1:0] VIDEO_GROUPS = 2'h2;

    localparam pos_t UPD_LEN       = pos_t'(2 * UPD_TK);
    localparam pos_t CYCLE_TK      = pos_t'(2 * ON_TK);
    localparam pos_t VIDEO_ON_END  = pos_t'(VIDEO_CYCLES * CYCLE_TK);
    localparam pos_t MEMORY_ON_END = pos_t'(MEMORY_CYCLES * CYCLE_TK);
    localparam pos_t VIDEO_LEN     = pos_t'(VIDEO_ON_END + PAUSE_TK);
    localparam pos_t MEMORY_LEN    = pos_t'(MEMORY_ON_END + PAUSE_TK);
    localparam pos_t THERM_LEN     = pos_t'(THERM_BEEPS * TBEEP_TK);

    // ----------------------------------------------------------------
    // Conditions, modes and records
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        COND_SETUP,
        COND_UPDATE,
        COND_VIDEO,
        COND_MEMORY,
        COND_THERMAL
    } cond_e;

    typedef enum logic [2:0] {
        M_IDLE,
        M_SETUP,
        M_UPDATE,
        M_VIDEO,
        M_MEMORY,
        M_THERMAL,
        M_HALT
    } mode_e;

    typedef struct packed {
        logic  valid;
        cond_e cond;
        logic  done;
    } req_s;

    typedef struct packed {
        mode_e             mode;
        logic [PRE_W-1:0]  pre;
        pos_t              pos;
        logic [1:0]        grp;
        logic              spk_en;
        logic              hi;
        logic              led;
        logic              shut;
    } seq_s;

    typedef struct packed {
        logic [HALF_W-1:0] cnt;
        logic              out;
    } tone_s;

endpackage

// ===== tone_gen.sv
/*
 * Square-wave tone divider: toggles its output every half period while
 * enabled, and holds it low otherwise.
 * Assumes the half period changes only between tones or while disabled.
 */
`timescale 1ns/1ps

module tone_gen
    import beep_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              en,
    input  wire logic [HALF_W-1:0] half,
    output logic                   tone_q
);

    tone_s q;
    tone_s d;

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // R11 divided square wave
        if (!en) begin
            d = '0;
        end else if (q.cnt >= half - 1'b1) begin
            d.cnt = '0;
            d.out = ~q.out;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tone_q = q.out;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_tone_silent: assert property (@(posedge core_clk) disable iff (!resetn) // R11
        !en |=> !tone_q && q.cnt == '0)
        else $error("tone output not silenced after disable");

    a_tone_edge: assert property (@(posedge core_clk) disable iff (!resetn) // R11
        en && $past(en) && (q.out != $past(q.out)) |-> q.cnt == '0)
        else $error("tone toggled off its half period");

endmodule

// ===== beep_seq.sv
/*
 * Start-up beep and blink sequencer: plays speaker and power LED
 * patterns for setup prompt, firmware update, video, memory and
 * thermal conditions.
 * Assumes the requester is logic on core_clk raising one condition
 * at a time with a one-cycle valid pulse.
 */
// Operation
// R1 - A reported recoverable error plays a speaker pattern chosen by its condition type
// R2 - Setup prompt: one 0.5 s beep at 932 Hz, then silence
// R3 - Update: speaker silent, LED off then 0.5 s on/off until complete
// R4 - Video: two 1 s beep/1 s gaps, 2.5 s pause, group once more
// R5 - Video LED: two 1 s blinks, 2.5 s off, repeating forever
// R6 - Requester raises video error only when no video option code is found
// R7 - Memory: three 1 s beeps at 932 Hz, 2.5 s pause, repeating forever
// R8 - Memory LED: three 1 s blinks, 2.5 s off, repeating forever
// R9 - Thermal: eight 1 s beeps alternating 2000/1500 Hz, then shutdown
// R10 - Thermal LED: two 0.25 s blinks per beep, sixteen in all
// R11 - Tones divided from clock; intervals from a reset-cleared tick prescaler
// R12 - Idle keeps speaker silent, LED normal; a new request restarts its pattern
`timescale 1ns/1ps

module beep_seq
    import beep_pkg::*;
#(
    parameter int                TICK_CYCLES = TICK_CYC_DEF,
    parameter logic [HALF_W-1:0] HALF_STD    = HALF_W'(HALF_STD_DEF),
    parameter logic [HALF_W-1:0] HALF_HIGH   = HALF_W'(HALF_HIGH_DEF),
    parameter logic [HALF_W-1:0] HALF_LOW    = HALF_W'(HALF_LOW_DEF)
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire req_s req,
    input  wire logic power_led_norm,
    output logic      spk_q,
    output logic      led_q,
    output logic      shutdown_q
);

    seq_s              st_q;
    seq_s              st_d;
    logic              tick;
    logic [HALF_W-1:0] half_sel;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // R11 quarter-second prescaler
        tick = (st_q.pre == PRE_W'(TICK_CYCLES - 1));
        st_d.pre = tick ? '0 : st_q.pre + 1'b1;
        if (tick) begin
            st_d.pos = st_q.pos + 1'b1;
        end
        case (st_q.mode)
            M_SETUP: begin
                if (tick && st_q.pos == SETUP_TK - 1'b1) begin
                    st_d.mode = M_IDLE;
                end
            end
            M_UPDATE: begin
                if (tick && st_q.pos == UPD_LEN - 1'b1) begin
                    st_d.pos = '0;
                end
                // R3 ends on complete
                if (req.done) begin
                    st_d.mode = M_IDLE;
                end
            end
            M_VIDEO: begin
                if (tick && st_q.pos == VIDEO_LEN - 1'b1) begin
                    st_d.pos = '0;
                    // R4 count groups
                    if (st_q.grp != VIDEO_GROUPS) begin
                        st_d.grp = st_q.grp + 1'b1;
                    end
                end
            end
            M_MEMORY: begin
                if (tick && st_q.pos == MEMORY_LEN - 1'b1) begin
                    st_d.pos = '0;
                end
            end
            M_THERMAL: begin
                // R9 shutdown after eighth
                if (tick && st_q.pos == THERM_LEN - 1'b1) begin
                    st_d.mode = M_HALT;
                    st_d.shut = 1'b1;
                end
            end
            M_IDLE, M_HALT: begin
                st_d.pos = '0;
            end
            default: begin
                st_d.mode = M_IDLE;
            end
        endcase
        // R12 restart from beginning
        if (req.valid) begin
            st_d.pre = '0;
            st_d.pos = '0;
            st_d.grp = '0;
            // R1 pattern by type
            case (req.cond)
                COND_SETUP:   st_d.mode = M_SETUP;
                COND_UPDATE:  st_d.mode = M_UPDATE;
                COND_VIDEO:   st_d.mode = M_VIDEO;
                COND_MEMORY:  st_d.mode = M_MEMORY;
                COND_THERMAL: st_d.mode = M_THERMAL;
                default:      st_d.mode = st_q.mode;
            endcase
        end
        if (st_d.mode == M_IDLE || st_d.mode == M_HALT) begin
            st_d.pos = '0;
        end
        // Indications follow the next position so they line up with it
        st_d.spk_en = 1'b0;
        st_d.hi     = 1'b0;
        st_d.led    = 1'b0;
        case (st_d.mode)
            M_IDLE: begin
                // R12 normal power LED
                st_d.led = power_led_norm;
            end
            M_SETUP: begin
                // R2 single beep
                st_d.spk_en = (st_d.pos < SETUP_TK);
                st_d.led    = power_led_norm;
            end
            M_UPDATE: begin
                // R3 off first, then blink
                st_d.led = (st_d.pos >= UPD_TK);
            end
            M_VIDEO: begin
                // R5 endless blink groups
                st_d.led    = (st_d.pos < VIDEO_ON_END) && ((st_d.pos % CYCLE_TK) < ON_TK);
                // R4 beeps only for two groups
                st_d.spk_en = st_d.led && (st_d.grp != VIDEO_GROUPS);
            end
            M_MEMORY: begin
                // R7 R8 three on-off then pause
                st_d.led    = (st_d.pos < MEMORY_ON_END) && ((st_d.pos % CYCLE_TK) < ON_TK);
                st_d.spk_en = st_d.led;
            end
            M_THERMAL: begin
                // R9 alternate high and low
                st_d.spk_en = 1'b1;
                st_d.hi     = (st_d.pos % pos_t'(2 * TBEEP_TK)) < TBEEP_TK;
                // R10 two blinks per beep
                st_d.led    = (st_d.pos % pos_t'(2 * TBLINK_TK)) < TBLINK_TK;
            end
            default: begin
                st_d.led = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{mode: M_IDLE, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Tone and outputs
    // ----------------------------------------------------------------
    // Thermal low tone only when not high; other patterns use the standard pitch
    assign half_sel = (st_q.mode == M_THERMAL) ? (st_q.hi ? HALF_HIGH : HALF_LOW) : HALF_STD;

    tone_gen u_tone (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (st_q.spk_en),
        .half     (half_sel),
        .tone_q   (spk_q)
    );

    assign led_q      = st_q.led;
    assign shutdown_q = st_q.shut;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_setup_beep: assert property ( // R2
        st_q.mode == M_SETUP |-> st_q.spk_en == (st_q.pos < SETUP_TK) && half_sel == HALF_STD)
        else $error("setup beep length or pitch wrong");

    a_update_blink: assert property ( // R3
        st_q.mode == M_UPDATE |-> !st_q.spk_en && st_q.led == (st_q.pos >= UPD_TK))
        else $error("update pattern wrong");

    a_video_stop: assert property ( // R4
        st_q.mode == M_VIDEO && st_q.grp == VIDEO_GROUPS |-> !st_q.spk_en)
        else $error("video beeps beyond two groups");

    a_video_led: assert property ( // R5
        st_q.mode == M_VIDEO && st_q.pos >= VIDEO_ON_END |-> !st_q.led)
        else $error("video LED on during pause");

    a_memory_beep: assert property ( // R7
        st_q.mode == M_MEMORY |-> st_q.spk_en == ((st_q.pos < MEMORY_ON_END) && !st_q.pos[2]))
        else $error("memory beep pattern wrong");

    a_memory_led: assert property ( // R8
        st_q.mode == M_MEMORY && tick && st_q.pos == MEMORY_LEN - 1'b1 && !req.valid
        |=> st_q.pos == '0 && st_q.led)
        else $error("memory group did not restart");

    a_thermal_end: assert property ( // R9
        st_q.mode == M_THERMAL && tick && st_q.pos == THERM_LEN - 1'b1 && !req.valid
        |=> st_q.mode == M_HALT && shutdown_q && !st_q.spk_en)
        else $error("thermal sequence did not shut down");

    a_thermal_blink: assert property ( // R10
        st_q.mode == M_THERMAL |-> st_q.led == !st_q.pos[0] && st_q.hi == !st_q.pos[2])
        else $error("thermal blink or pitch wrong");

    a_tick_range: assert property ( // R11
        st_q.pre < PRE_W'(TICK_CYCLES) and (tick |=> st_q.pre == '0))
        else $error("prescaler out of range");

    a_req_restart: assert property ( // R12
        req.valid |=> st_q.pos == '0 && st_q.pre == '0 && st_q.grp == '0)
        else $error("request did not restart pattern");

    a_idle_quiet: assert property ( // R12
        st_q.mode == M_IDLE |-> !st_q.spk_en && st_q.led == $past(power_led_norm))
        else $error("idle indication wrong");

    c_video_done:   cover property (st_q.mode == M_VIDEO && st_q.grp == VIDEO_GROUPS);
    c_thermal_halt: cover property (st_q.mode == M_HALT);
    c_update_done:  cover property (st_q.mode == M_UPDATE && req.done);
    c_memory_wrap:  cover property (st_q.mode == M_MEMORY && tick && st_q.pos == MEMORY_LEN - 1'b1);

endmodule

// ===== spk_led_model.sv
/*
 * Far-side model of the board speaker and the front-panel power LED:
 * counts tone rises, lit cycles and the last tone half period.
 * Assumes spk_q and led_q are registered on core_clk.
 */
`timescale 1ns/1ps

module spk_led_model (
    input  wire logic       core_clk,
    input  wire logic       clr,
    input  wire logic       spk_q,
    input  wire logic       led_q,
    output logic [7:0]      rises,
    output logic [7:0]      lit,
    output logic [7:0]      half
);
    logic       prev_q;
    logic [7:0] gap_q;

    // ------------------------------------------------------------
    // Listener and viewer
    // ------------------------------------------------------------
    initial begin
        prev_q = 1'b0;
        gap_q  = 8'h00;
        rises  = 8'h00;
        lit    = 8'h00;
        half   = 8'h00;
    end

    // Half period taken between two toggles, so one stray edge shows
    always @(posedge core_clk) begin
        prev_q <= spk_q;
        gap_q  <= (spk_q != prev_q) ? 8'h01 : gap_q + 8'h01;
        if (spk_q != prev_q) begin
            half <= gap_q;
        end
        rises <= clr ? 8'h00 : rises + 8'(spk_q && !prev_q);
        lit   <= clr ? 8'h00 : lit + 8'(led_q);
    end
endmodule

// ===== tb.sv
/*
 * Self-checking bench for the beep and blink sequencer: plays every
 * condition, aborts, an invalid code, update completion and shutdown.
 * Assumes shortened ticks and half periods; inputs change at negedge.
 */
`timescale 1ns/1ps

module tb;
    import beep_pkg::*;

    localparam int                T     = 8;
    localparam logic [HALF_W-1:0] H_STD = 16'h0003;
    localparam logic [HALF_W-1:0] H_HI  = 16'h0001;
    localparam logic [HALF_W-1:0] H_LO  = 16'h0002;

    logic       core_clk       = 1'b0;
    logic       resetn         = 1'b0;
    logic       power_led_norm = 1'b0;
    logic       clr            = 1'b1;
    logic       sd             = 1'b0;
    req_s       req            = '0;
    logic       spk_q;
    logic       led_q;
    logic       shutdown_q;
    logic [7:0] rises;
    logic [7:0] lit;
    logic [7:0] half;
    int         miscompares    = 0;
    int         check_count    = 0;
    int         seed           = 78;

    always #5 core_clk = ~core_clk;

    beep_seq #(.TICK_CYCLES(T), .HALF_STD(H_STD), .HALF_HIGH(H_HI), .HALF_LOW(H_LO)) u_dut (
        .core_clk       (core_clk),
        .resetn         (resetn),
        .req            (req),
        .power_led_norm (power_led_norm),
        .spk_q          (spk_q),
        .led_q          (led_q),
        .shutdown_q     (shutdown_q)
    );

    spk_led_model u_far (
        .core_clk (core_clk),
        .clr      (clr),
        .spk_q    (spk_q),
        .led_q    (led_q),
        .rises    (rises),
        .lit      (lit),
        .half     (half)
    );

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic logic exp_led(cond_e c, int t, logic n);
        case (c)
            COND_UPDATE: return (t % 4) >= 2;
            COND_VIDEO: return (t % 26) < 16 && ((t % 26) % 8) < 4;
            COND_MEMORY: return (t % 34) < 24 && ((t % 34) % 8) < 4;
            COND_THERMAL: return t < 32 && (t % 2) == 0;
            default: return n;
        endcase
    endfunction

    function automatic logic exp_spk(cond_e c, int t);
        case (c)
            COND_SETUP: return t < 2;
            COND_VIDEO: return t < 52 && exp_led(c, t, 1'b0);
            COND_MEMORY: return exp_led(c, t, 1'b0);
            COND_THERMAL: return t < 32;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] exp_half(cond_e c, int t);
        if (c == COND_THERMAL) begin
            return ((t / 4) % 2) ? 8'(H_LO) : 8'(H_HI);
        end
        return 8'(H_STD);
    endfunction

    // ------------------------------------------------------------
    // Compares and closing
    // ------------------------------------------------------------
    task automatic chk_bit(logic got, logic exp, string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(logic [7:0] got, logic [7:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %0d want %0d", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Pulse r, then judge ticks t0..t0+n-1 of pattern c, window of T-2 cycles
    task automatic run(req_s r, cond_e c, int t0, int n);
        logic nv;
        req = r;
        @(negedge core_clk);
        req = '0;
        for (int i = t0; i < t0 + n; i++) begin
            // Sampled as the tick opens, after the edge that sets it
            chk_bit(shutdown_q, sd | (c == COND_THERMAL && i >= 32), "shutdown");
            nv = 1'($random(seed));
            clr = 1'b1;
            power_led_norm = nv;
            repeat (2) @(negedge core_clk);
            clr = 1'b0;
            repeat (T - 2) @(negedge core_clk);
            chk_cnt(lit, exp_led(c, i, nv) ? 8'(T - 2) : 8'h00, "led lit");
            chk_bit(rises != 8'h00, exp_spk(c, i), "tone");
            if (exp_spk(c, i) && (i % 4) != 0) begin
                chk_cnt(half, exp_half(c, i), "half period");
            end
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        run('{1'b1, COND_SETUP, 1'b0}, COND_SETUP, 0, 4);
        run('{1'b1, COND_UPDATE, 1'b0}, COND_UPDATE, 0, 10);
        run('{1'b0, COND_SETUP, 1'b1}, COND_SETUP, 2, 3);
        // video raised as if no video option code were found
        run('{1'b1, COND_VIDEO, 1'b0}, COND_VIDEO, 0, 5 + ($unsigned($random(seed)) % 15));
        run('{1'b1, COND_MEMORY, 1'b0}, COND_MEMORY, 0, 12);
        run('{1'b1, cond_e'(3'h5), 1'b0}, COND_MEMORY, 0, 68);
        run('{1'b1, COND_VIDEO, 1'b0}, COND_VIDEO, 0, 80);
        run('{1'b1, COND_THERMAL, 1'b0}, COND_THERMAL, 0, 35);
        sd = 1'b1;
        // Shutdown stays set; a new request still plays
        run('{1'b1, COND_SETUP, 1'b0}, COND_SETUP, 0, 3);
        report_and_stop();
    end

    // Hang guard, well beyond the roughly 2,000 cycles of the sequence
    initial begin
        repeat (10000) @(posedge core_clk);
        miscompares++;
        report_and_stop();
    end
endmodule
